// file: design/ppm_cfg.svh
/*
 * Constants of the peripheral pin mux and interrupt routing block:
 * identifiers, masks, reset values and group and port counts.
 * Assumes it is included by bare name from the package and design modules.
 */
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH

// ==========================================================
// Peripheral identifiers
`define PPM_ID_FIQ 0
`define PPM_ID_SYSTEM_CONTROLLER_GROUP 1
`define PPM_ID_TC 19
`define PPM_ID_UHP 29
`define PPM_ID_EXTERNAL_INTERRUPT_ZERO 30
`define PPM_ID_EXTERNAL_INTERRUPT_ONE 31
// Identifiers whose clock set and clear bits have no effect.
`define PPM_NOGATE_MASK 32'he0000003
`define PPM_CLKEN_RESET 32'h00000000

// ==========================================================
// Merged interrupt groups
`define PPM_NSYS 7
`define PPM_NTC 3

// ==========================================================
// Port controllers
`define PPM_NPORT 5
`define PPM_NLINE 32
`define PPM_PORT_D 3
// Port D lines 12 to 14 carry address bits 23 to 25 and reset in function A.
`define PPM_RST_FUNC_D 32'h00007000
`define PPM_RST_FUNC_IO 32'h00000000
`define PPM_RST_SELB 32'h00000000
`define PPM_RST_PULLUP 32'hffffffff

`endif

// file: design/ppm_line_if.sv
/*
 * Carrier between the top module and one port controller.
 * Assumes the top drives the controls and the controller drives the results.
 */
interface ppm_line_if #(parameter int W = 32);
    // Control pulses and levels from the owner of the port.
    logic [W-1:0] funcSet, funcClr, selBSet, selASet, pullOff, pullOn;
    logic [W-1:0] gpioOut, gpioOe, aOut, aOe, bOut, bOe, padIn;
    // Results from the port controller.
    logic [W-1:0] aIn, bIn, gpioIn, funcStatus, padOut, padOe, padPullUp;

    modport ctl (
        output funcSet, funcClr, selBSet, selASet, pullOff, pullOn,
        output gpioOut, gpioOe, aOut, aOe, bOut, bOe, padIn,
        input aIn, bIn, gpioIn, funcStatus, padOut, padOe, padPullUp
    );
    modport mux (
        input funcSet, funcClr, selBSet, selASet, pullOff, pullOn,
        input gpioOut, gpioOe, aOut, aOe, bOut, bOe, padIn,
        output aIn, bIn, gpioIn, funcStatus, padOut, padOe, padPullUp
    );
endinterface

// file: design/ppm_pkg.sv
/*
 * Types shared by the pin mux and interrupt routing modules.
 * Assumes ppm_cfg.svh is on the include path.
 */
`include "ppm_cfg.svh"

package ppm_pkg;
    // ==========================================================
    // Types
    typedef logic [`PPM_NLINE-1:0] ppm_word_t;
    typedef logic [`PPM_NPORT-1:0][`PPM_NLINE-1:0] ppm_portvec_t;
    typedef logic [`PPM_NSYS-1:0] ppm_sys_t;
    typedef logic [`PPM_NTC-1:0] ppm_tc_t;
    typedef enum logic [1:0] {
        PPM_FN_IO = 2'b00,
        PPM_FN_A = 2'b01,
        PPM_FN_B = 2'b10
    } ppm_func_t;
endpackage

// file: design/ppm_port_mux.sv
/*
 * One I/O port controller: per line choice of general I/O, function A or B.
 * Assumes pad inputs come from outside the clock domain and the rest
 * comes from logic on mclk.
 */
`include "ppm_cfg.svh"

module ppm_port_mux
    import ppm_pkg::*;
#(
    parameter int W = 32,
    parameter logic [W-1:0] RST_FUNC = '0
) (
    // Clock, reset, enable.
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // Port side.
    ppm_line_if.mux lp
);
    // ==========================================================
    // State
    logic [W-1:0] funcQ, selBQ, pullQ, sync1Q, sync2Q, sync3Q, filtQ;
    logic [W-1:0] outQ, oeQ, aInQ, bInQ, gpioInQ;
    logic [W-1:0] outD, oeD;

    // Function select: a set beats a clear arriving in the same cycle.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            funcQ <= RST_FUNC;
            selBQ <= `PPM_RST_SELB;
        end else if (ce) begin
            funcQ <= (funcQ & ~lp.funcClr) | lp.funcSet;
            selBQ <= (selBQ & ~lp.selASet) | lp.selBSet;
        end
    end

    // Pull-ups come out of reset enabled on every line.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pullQ <= `PPM_RST_PULLUP;
        end else if (ce) begin
            pullQ <= (pullQ & ~lp.pullOff) | lp.pullOn;
        end
    end

    // Three-stage sampling of the pads; a change counts once stages two
    // and three agree, which also drops single-cycle glitches.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1Q <= '0;
            sync2Q <= '0;
            sync3Q <= '0;
            filtQ <= '0;
        end else if (ce) begin
            sync1Q <= lp.padIn;
            sync2Q <= sync1Q;
            sync3Q <= sync2Q;
            filtQ <= (filtQ & ~(sync2Q ~^ sync3Q)) | (sync2Q & sync3Q);
        end
    end

    // Pad drive follows the selected owner of each line.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!funcQ[i]) begin
                outD[i] = lp.gpioOut[i];
                oeD[i] = lp.gpioOe[i]; // I/O lines drive only while gpioOe is set.
            end else if (selBQ[i]) begin
                outD[i] = lp.bOut[i];
                oeD[i] = lp.bOe[i];
            end else begin
                outD[i] = lp.aOut[i];
                oeD[i] = lp.aOe[i];
            end
        end
    end

    // Registered pad drive and forwarded inputs; unselected functions see 0.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            outQ <= '0;
            oeQ <= '0;
            aInQ <= '0;
            bInQ <= '0;
            gpioInQ <= '0;
        end else if (ce) begin
            outQ <= outD;
            oeQ <= oeD;
            aInQ <= filtQ & funcQ & ~selBQ;
            bInQ <= filtQ & funcQ & selBQ;
            gpioInQ <= filtQ;
        end
    end

    assign lp.padOut = outQ;
    assign lp.padOe = oeQ;
    assign lp.padPullUp = pullQ;
    assign lp.aIn = aInQ;
    assign lp.bIn = bInQ;
    assign lp.gpioIn = gpioInQ;
    assign lp.funcStatus = funcQ;

    // ==========================================================
    // Checks
    sequence s_padHigh;
        (ce && lp.padIn[0])[*4];
    endsequence

    property p_padFilter;
        @(posedge mclk) disable iff (!rst_b) s_padHigh |=> filtQ[0];
    endproperty
    a_padFilter: assert property (p_padFilter) else $error("Pad level not forwarded.");

    property p_driveA;
        @(posedge mclk) disable iff (!rst_b)
            (ce && funcQ[0] && !selBQ[0]) |=> (outQ[0] == $past(lp.aOut[0]) && oeQ[0] == $past(lp.aOe[0]));
    endproperty
    a_driveA: assert property (p_driveA) else $error("Function A not on pad.");

    property p_ioInput;
        @(posedge mclk) disable iff (!rst_b)
            (ce && !funcQ[1] && !lp.gpioOe[1]) |=> !oeQ[1];
    endproperty
    a_ioInput: assert property (p_ioInput) else $error("I/O line drives without enable.");

    property p_setWins;
        @(posedge mclk) disable iff (!rst_b)
            (ce && lp.funcSet[2] && lp.funcClr[2]) |=> funcQ[2];
    endproperty
    a_setWins: assert property (p_setWins) else $error("Function set lost to clear.");
endmodule

// file: design/ppm_top.sv
/*
 * Chip glue: merged interrupt sources, peripheral clock gates and five
 * 32-line I/O port controllers with function A/B multiplexing.
 * Assumes peripherals, interrupt unit and clock manager run on mclk; pads
 * are asynchronous to it.
 */
// Overview of operation
// - Clock writes to ungated identifiers do nothing.
// - Source one ORs seven system interrupts.
// - System clock runs from the first enabled edge after reset; identifier one ungated.
// - External interrupt identifiers never gate clocks.
// - Three timer interrupts OR into source nineteen.
// - One gate nineteen clocks all timer channels.
// - Five port controllers of thirty-two lines.
// - Each line: I/O, function A or B.
// - I/O reset lines: input, pull-up, status zero.
// - Function reset lines: assigned, status one, pull-up.
// - Port D address lines reset as function.
// - Duplicated output functions carry the same signal.
`include "ppm_cfg.svh"

module ppm_top
    import ppm_pkg::*;
#(
    parameter int NPORT = `PPM_NPORT,
    parameter int NLINE = `PPM_NLINE
) (
    // Clock, reset, enable.
    mclk,
    rst_b,
    ce,
    // Clock manager side.
    clkSetWr,
    clkClrWr,
    clkWrData,
    clkEnabled,
    tcClkEn,
    sysClkEn,
    // Interrupt sources.
    sysIrq,
    tcIrq,
    periphIrq,
    irqSrc,
    // Port control from the I/O controllers' owners.
    funcSetMask,
    funcClrMask,
    selBSetMask,
    selASetMask,
    pullOffMask,
    pullOnMask,
    gpioOut,
    gpioOe,
    gpioIn,
    funcStatus,
    // Peripheral functions.
    perAOut,
    perAOe,
    perBOut,
    perBOe,
    perAIn,
    perBIn,
    // Pads.
    padIn,
    padOut,
    padOe,
    padPullUp
);
    input wire logic mclk;
    input wire logic rst_b;
    input wire logic ce;
    input wire logic clkSetWr;
    input wire logic clkClrWr;
    input wire ppm_pkg::ppm_word_t clkWrData;
    output ppm_pkg::ppm_word_t clkEnabled;
    output ppm_pkg::ppm_tc_t tcClkEn;
    output logic sysClkEn;
    input wire ppm_pkg::ppm_sys_t sysIrq;
    input wire ppm_pkg::ppm_tc_t tcIrq;
    input wire ppm_pkg::ppm_word_t periphIrq;
    output ppm_pkg::ppm_word_t irqSrc;
    input wire ppm_pkg::ppm_portvec_t funcSetMask;
    input wire ppm_pkg::ppm_portvec_t funcClrMask;
    input wire ppm_pkg::ppm_portvec_t selBSetMask;
    input wire ppm_pkg::ppm_portvec_t selASetMask;
    input wire ppm_pkg::ppm_portvec_t pullOffMask;
    input wire ppm_pkg::ppm_portvec_t pullOnMask;
    input wire ppm_pkg::ppm_portvec_t gpioOut;
    input wire ppm_pkg::ppm_portvec_t gpioOe;
    output ppm_pkg::ppm_portvec_t gpioIn;
    output ppm_pkg::ppm_portvec_t funcStatus;
    input wire ppm_pkg::ppm_portvec_t perAOut;
    input wire ppm_pkg::ppm_portvec_t perAOe;
    input wire ppm_pkg::ppm_portvec_t perBOut;
    input wire ppm_pkg::ppm_portvec_t perBOe;
    output ppm_pkg::ppm_portvec_t perAIn;
    output ppm_pkg::ppm_portvec_t perBIn;
    input wire ppm_pkg::ppm_portvec_t padIn;
    output ppm_pkg::ppm_portvec_t padOut;
    output ppm_pkg::ppm_portvec_t padOe;
    output ppm_pkg::ppm_portvec_t padPullUp;

    // ==========================================================
    // Clock gates
    ppm_word_t clkEnQ;
    ppm_tc_t tcClkQ;
    logic sysClkQ;
    ppm_word_t setBits, clrBits;

    // Gateable bits only; the interrupt unit, system group, host port and
    // external interrupt identifiers have no gate, so writes there vanish.
    assign setBits = clkSetWr ? (clkWrData & ~`PPM_NOGATE_MASK) : '0;
    assign clrBits = clkClrWr ? (clkWrData & ~`PPM_NOGATE_MASK) : '0;

    // Enable wins when set and clear of one bit meet in a cycle.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clkEnQ <= `PPM_CLKEN_RESET;
        end else if (ce) begin
            clkEnQ <= (clkEnQ & ~clrBits) | setBits;
        end
    end

    // The timer channels share one gate; there is no per-channel control.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tcClkQ <= '0;
            sysClkQ <= 1'b0;
        end else if (ce) begin
            tcClkQ <= {`PPM_NTC{clkEnQ[`PPM_ID_TC]}};
            sysClkQ <= 1'b1;
        end
    end

    assign clkEnabled = clkEnQ;
    assign tcClkEn = tcClkQ;
    assign sysClkEn = sysClkQ;

    // ==========================================================
    // Interrupt routing
    ppm_word_t irqQ, irqD;

    // Merged sources hide which unit asked; the handler must poll each one.
    always_comb begin
        irqD = periphIrq;
        irqD[`PPM_ID_SYSTEM_CONTROLLER_GROUP] = |sysIrq;
        irqD[`PPM_ID_TC] = |tcIrq;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irqQ <= '0;
        end else if (ce) begin
            irqQ <= irqD;
        end
    end

    assign irqSrc = irqQ;

    // ==========================================================
    // Port controllers
    // A duplicated output-only signal is wired by the owner to every line
    // offering it, so each selected line drives the identical value.
    for (genvar g = 0; g < NPORT; g++) begin : gPort
        ppm_line_if #(.W(NLINE)) lineIf();

        assign lineIf.funcSet = funcSetMask[g];
        assign lineIf.funcClr = funcClrMask[g];
        assign lineIf.selBSet = selBSetMask[g];
        assign lineIf.selASet = selASetMask[g];
        assign lineIf.pullOff = pullOffMask[g];
        assign lineIf.pullOn = pullOnMask[g];
        assign lineIf.gpioOut = gpioOut[g];
        assign lineIf.gpioOe = gpioOe[g];
        assign lineIf.aOut = perAOut[g];
        assign lineIf.aOe = perAOe[g];
        assign lineIf.bOut = perBOut[g];
        assign lineIf.bOe = perBOe[g];
        assign lineIf.padIn = padIn[g];
        assign perAIn[g] = lineIf.aIn;
        assign perBIn[g] = lineIf.bIn;
        assign gpioIn[g] = lineIf.gpioIn;
        assign funcStatus[g] = lineIf.funcStatus;
        assign padOut[g] = lineIf.padOut;
        assign padOe[g] = lineIf.padOe;
        assign padPullUp[g] = lineIf.padPullUp;

        ppm_port_mux #(
            .W(NLINE),
            .RST_FUNC((g == `PPM_PORT_D) ? `PPM_RST_FUNC_D : `PPM_RST_FUNC_IO)
        ) uMux (
            .mclk(mclk),
            .rst_b(rst_b),
            .ce(ce),
            .lp(lineIf.mux)
        );
    end

    // ==========================================================
    // Checks
    logic firstQ;

    // Marks the first edge after reset release, for reset-state checks.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            firstQ <= 1'b1;
        end else begin
            firstQ <= 1'b0;
        end
    end

    property p_sysIrq;
        @(posedge mclk) disable iff (!rst_b) ce |=> irqSrc[1] == $past(|sysIrq);
    endproperty
    a_sysIrq: assert property (p_sysIrq) else $error("Source one not the system OR.");

    property p_tcIrq;
        @(posedge mclk) disable iff (!rst_b) ce |=> irqSrc[19] == $past(|tcIrq);
    endproperty
    a_tcIrq: assert property (p_tcIrq) else $error("Source nineteen not the timer OR.");

    property p_noGate;
        @(posedge mclk) disable iff (!rst_b) (ce && (clkSetWr || clkClrWr)) |=>
            (clkEnabled & `PPM_NOGATE_MASK) == '0;
    endproperty
    a_noGate: assert property (p_noGate) else $error("Ungated identifier changed.");

    property p_extIds;
        @(posedge mclk) disable iff (!rst_b)
            !clkEnabled[0] && !clkEnabled[30] && !clkEnabled[31];
    endproperty
    a_extIds: assert property (p_extIds) else $error("External interrupt id gated.");

    sequence s_tcOff;
        ce && clkClrWr && !clkSetWr && clkWrData[19] ##1 ce;
    endsequence

    property p_tcGate;
        @(posedge mclk) disable iff (!rst_b) s_tcOff |=> tcClkEn == 3'h0;
    endproperty
    a_tcGate: assert property (p_tcGate) else $error("Timer channels not stopped together.");

    property p_sysClk;
        @(posedge mclk) disable iff (!rst_b) (ce && !firstQ) |=> sysClkEn;
    endproperty
    a_sysClk: assert property (p_sysClk) else $error("System clock stopped.");

    property p_resetFunc;
        @(posedge mclk) disable iff (!rst_b) firstQ |->
            funcStatus[3] == `PPM_RST_FUNC_D && funcStatus[0] == '0 && padPullUp[0] == '1;
    endproperty
    a_resetFunc: assert property (p_resetFunc) else $error("Line reset state wrong.");
endmodule

// file: verification/ppm_periph_model.sv
/*
 * Far-side model: peripherals and interrupt sources feeding the glue.
 * Assumes the bench seeds it during reset and raises run afterwards.
 */
module ppm_periph_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_b,
    // Control from the bench.
    input wire logic run,
    input wire ppm_pkg::ppm_word_t seed,
    input wire logic tcSrcSeen,
    // Drive into the glue.
    output ppm_pkg::ppm_sys_t sysIrq,
    output ppm_pkg::ppm_tc_t tcIrq,
    output ppm_pkg::ppm_word_t periphIrq,
    output ppm_pkg::ppm_portvec_t aOut,
    output ppm_pkg::ppm_portvec_t aOe,
    output ppm_pkg::ppm_portvec_t bOut,
    output ppm_pkg::ppm_portvec_t bOe,
    output ppm_pkg::ppm_tc_t tcRead
);
    timeunit 1ns;
    timeprecision 1ps;
    import ppm_pkg::*;
    ppm_word_t st;

    // =========================================================
    // Pattern source
    // Xorshift step, so the nonzero state takes a new value each cycle.
    function automatic ppm_word_t nxt(ppm_word_t v);
        ppm_word_t r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    // Registered like any on-chip peripheral; never holds a kind value.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= seed | 32'h00000001;
            {sysIrq, tcIrq, periphIrq} <= '0;
            {aOut, aOe, bOut, bOe} <= '0;
            tcRead <= '0;
        end else if (run) begin
            st <= nxt(st);
            sysIrq <= st[6:0] & st[13:7];
            tcIrq <= st[2:0] & st[10:8];
            periphIrq <= st & nxt(st);
            for (int p = 0; p < 5; p++) begin
                aOut[p] <= st ^ (st >> p);
                aOe[p] <= st ^ (st << p);
                bOut[p] <= ~st ^ (st >> (p + 7));
                bOe[p] <= ~st ^ (st << (p + 3));
            end
            // One output-only function offered on two lines carries one signal.
            bOut[1][8] <= st[3];
            bOut[2][3] <= st[3];
            // Shared timer source: all three statuses are read before dispatch.
            if (tcSrcSeen) begin
                tcRead <= tcIrq;
            end
        end
    end
endmodule

// file: verification/tb_ppm_top.sv
/*
 * Self-checking bench for the pin mux and interrupt routing glue.
 * Assumes the design files and the far-side model are compiled first.
 */
`include "ppm_cfg.svh"

`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); nMismatch++; end end

module tb_ppm_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ppm_pkg::*;
    logic mclk, rst_b, ce, clkSetWr, clkClrWr, sysClkEn, run, chk, padChk;
    ppm_word_t clkWrData, clkEnabled, periphIrq, irqSrc, clkM, irqM, seedW;
    ppm_tc_t tcClkEn, tcIrq, tcM;
    ppm_sys_t sysIrq;
    ppm_portvec_t fSet, fClr, bSet, aSet, pOff, pOn, gOut, gOe, gIn, fStat;
    ppm_portvec_t aOut, aOe, bOut, bOe, aIn, bIn, padIn, padOut, padOe, padPu;
    ppm_portvec_t fM, sM, pM, oM, eM, padM;
    logic sysM;
    int nMismatch = 0;
    int compares = 0;

    ppm_top dut_u (.mclk(mclk), .rst_b(rst_b), .ce(ce), .clkSetWr(clkSetWr),
        .clkClrWr(clkClrWr), .clkWrData(clkWrData), .clkEnabled(clkEnabled),
        .tcClkEn(tcClkEn), .sysClkEn(sysClkEn), .sysIrq(sysIrq), .tcIrq(tcIrq),
        .periphIrq(periphIrq), .irqSrc(irqSrc), .funcSetMask(fSet), .funcClrMask(fClr),
        .selBSetMask(bSet), .selASetMask(aSet), .pullOffMask(pOff), .pullOnMask(pOn),
        .gpioOut(gOut), .gpioOe(gOe), .gpioIn(gIn), .funcStatus(fStat), .perAOut(aOut),
        .perAOe(aOe), .perBOut(bOut), .perBOe(bOe), .perAIn(aIn), .perBIn(bIn),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullUp(padPu));

    ppm_periph_model per_u (.mclk(mclk), .rst_b(rst_b), .run(run), .seed(seedW),
        .tcSrcSeen(irqSrc[19]), .sysIrq(sysIrq), .tcIrq(tcIrq), .periphIrq(periphIrq),
        .aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe), .tcRead());

    // =========================================================
    // Reference model and checks
    // Stepped on the edge where the glue samples, so inputs are pre-edge values.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {clkM, tcM, sysM, irqM, oM, eM, sM} = '0;
            fM = '0;
            fM[3][14:12] = 3'h7;
            pM = '1;
        end else if (ce) begin
            for (int p = 0; p < 5; p++) begin
                oM[p] = (~fM[p] & gOut[p]) | (fM[p] & ~sM[p] & aOut[p]) | (fM[p] & sM[p] & bOut[p]);
                eM[p] = (~fM[p] & gOe[p]) | (fM[p] & ~sM[p] & aOe[p]) | (fM[p] & sM[p] & bOe[p]);
                fM[p] = (fM[p] & ~fClr[p]) | fSet[p];
                sM[p] = (sM[p] & ~aSet[p]) | bSet[p];
                pM[p] = (pM[p] & ~pOff[p]) | pOn[p];
            end
            tcM = {3{clkM[19]}};
            clkM = (clkM & ~(clkClrWr ? clkWrData : 32'h00000000)) | (clkSetWr ? clkWrData : 32'h00000000);
            clkM = clkM & ~`PPM_NOGATE_MASK;
            sysM = 1'b1;
            irqM = periphIrq;
            irqM[1] = |sysIrq;
            irqM[19] = |tcIrq;
        end
    end

    // Outputs are compared mid-cycle, well away from the launching edge.
    always @(negedge mclk) begin
        if (chk) begin
            `CHK("clkEnabled", clkM, clkEnabled)
            `CHK("ungatedIds", 5'h00, {clkEnabled[31:29], clkEnabled[1:0]})
            `CHK("sysClkEn", sysM, sysClkEn)
            `CHK("tcClkEn", tcM, tcClkEn)
            `CHK("irqSrc", irqM, irqSrc)
            `CHK("irqSrc19", irqM[19], irqSrc[19])
            `CHK("funcStatus", fM, fStat)
            `CHK("padOut", oM, padOut)
            `CHK("padOe", eM, padOe)
            `CHK("padPullUp", pM, padPu)
        end
        if (padChk) begin
            `CHK("gpioIn", padM, gIn)
            `CHK("perAIn", padM & fM & ~sM, aIn)
            `CHK("perBIn", padM & fM & sM, bIn)
        end
    end

    task automatic stop_test();
        if (nMismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic clkw(input logic s, input logic c, input ppm_word_t d);
        @(posedge mclk);
        clkSetWr <= s;
        clkClrWr <= c;
        clkWrData <= d;
    endtask

    // =========================================================
    // Stimulus
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard: no scenario comes near this bound.
    initial begin
        #500000;
        nMismatch++;
        stop_test();
    end

    initial begin
        seedW = $urandom(32'haa4b5963);
        {rst_b, clkSetWr, clkClrWr, clkWrData, run, chk, padChk} = '0;
        ce = 1'b1;
        {fSet, fClr, bSet, aSet, pOff, pOn, gOut, gOe, padIn, padM} = '0;
        repeat (2) @(posedge mclk);
        chk = 1'b1;
        repeat (18) @(posedge mclk);
        rst_b <= 1'b1;
        run <= 1'b1;
        // Back-to-back writes, then set and clear of one bit in one cycle.
        clkw(1'b1, 1'b0, 32'hffffffff);
        clkw(1'b0, 1'b1, 32'hffffffff);
        clkw(1'b1, 1'b1, 32'h00080000);
        clkw(1'b0, 1'b1, 32'h00080000);
        clkw(1'b0, 1'b0, 32'h00000000);
        for (int i = 0; i < 800; i++) begin
            @(posedge mclk);
            ce <= ($urandom % 8) != 0;
            clkSetWr <= 1'($urandom_range(1));
            clkClrWr <= 1'($urandom_range(1));
            clkWrData <= $urandom;
            for (int p = 0; p < 5; p++) begin
                fSet[p] <= $urandom & $urandom & $urandom;
                fClr[p] <= $urandom & $urandom & $urandom;
                bSet[p] <= $urandom & $urandom;
                aSet[p] <= $urandom & $urandom;
                pOff[p] <= $urandom & $urandom & $urandom;
                pOn[p] <= $urandom & $urandom & $urandom;
                gOut[p] <= $urandom;
                gOe[p] <= $urandom;
            end
        end
        @(posedge mclk);
        ce <= 1'b1;
        {clkSetWr, clkClrWr} <= 2'h0;
        {fSet, fClr, bSet, aSet, pOff, pOn} <= '0;
        // Reset in mid-run must restore every documented reset state.
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        fSet[2][3] <= 1'b1;
        bSet[2][3] <= 1'b1;
        fSet[1][8] <= 1'b1;
        bSet[1][8] <= 1'b1;
        @(posedge mclk);
        {fSet, bSet} <= '0;
        repeat (3) @(posedge mclk);
        #1 `CHK("dupOut", oM[1][8], padOut[2][3])
        // Steady pad levels pass through; a one-cycle glitch must not.
        for (int k = 0; k < 6; k++) begin
            padChk = 1'b0;
            @(posedge mclk);
            for (int p = 0; p < 5; p++) begin
                padIn[p] <= $urandom;
            end
            repeat (8) @(posedge mclk);
            padM = padIn;
            padChk = 1'b1;
            @(posedge mclk);
            padIn <= ~padM;
            @(posedge mclk);
            padIn <= padM;
            repeat (8) @(posedge mclk);
        end
        stop_test();
    end
endmodule
